// file: hdl/switch_spi_defs.vh
// Constants shared by the six-channel switch serial interface
`ifndef SWITCH_SPI_DEFS_VH
`define SWITCH_SPI_DEFS_VH

// Frame geometry, counted in falling serial-clock edges
`define FRAME_EDGES 5'd16
`define ADDR_LAST_EDGE 5'd1
`define INSTR_LAST_EDGE 5'd7
`define EDGE_CNT_MAX 5'd31
`define EDGE_CNT_ONE 5'd1

// Address pattern in instruction bits 7 and 6
`define ADDR_MATCH 2'b10

// Instruction codes, upper six bits of the instruction byte
`define OP_WRITE_SWITCH 6'h26
`define OP_READ_SWITCH 6'h25
`define OP_WRITE_SOURCE 6'h2a
`define OP_READ_SOURCE 6'h29
`define OP_READ_FAULT 6'h20

// Register reset values and filler bits
`define REG_RESET 8'hff
`define FILL_BITS 2'b11
`define Z_FILL 2'b11
`define CODE_OK 2'b11
`define FAULT_RESET 12'hfff
`define OT_NONE 1'b1
`define OT_SEEN 1'b0

// Synchroniser lane map and reset image
`define SYNC_W 30
`define SY_CS 0
`define SY_SCLK 1
`define SY_SI 2
`define SY_RESET_N 3
`define SY_UV 4
`define SY_POL 5
`define SY_PAR_LO 6
`define SY_PAR_HI 11
`define SY_CODE_LO 12
`define SY_CODE_HI 23
`define SY_HOT_LO 24
`define SY_HOT_HI 29
`define SYNC_INIT 30'h0fff009

`endif

// file: hdl/pin_sync.v
// Two-stage synchroniser for a bundle of asynchronous pins
`timescale 1ns/1ps
module pin_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
  input wire clk, // System clock
  input wire rst, // Synchronous reset, active high
  input wire [WIDTH-1:0] d, // Raw asynchronous inputs
  output wire [WIDTH-1:0] q // Synchronised inputs
);
  reg [WIDTH-1:0] meta_reg; // First stage, read only by second stage
  reg [WIDTH-1:0] sync_reg; // Second stage

  // Both stages reset to the idle image of the pins
  always @(posedge clk) begin
    if (rst) begin
      meta_reg <= INIT;
      sync_reg <= INIT;
    end else begin
      meta_reg <= d;
      sync_reg <= meta_reg;
    end
  end

  assign q = sync_reg;
endmodule // pin_sync

// file: hdl/six_channel_switch_spi_slave.v
// Serial command slave and output control of a six-channel low-side switch
`timescale 1ns/1ps
`include "switch_spi_defs.vh"
module six_channel_switch_spi_slave (
  input wire clk, // System clock, 125 MHz
  input wire rst, // Synchronous reset, active high
  input wire cs_n, // Chip select pin, active low
  input wire sclk, // Serial clock pin from the master
  input wire si, // Serial data in
  output wire so_out, // Serial data out level
  output wire so_oe_n, // Serial out enable, low while driving
  input wire reset_n, // External reset pin, active low
  input wire undervoltage, // Supply under-voltage detector, active high
  input wire input_polarity_pin, // High: parallel inputs high active
  input wire [5:0] parallel_control_input, // Parallel inputs, channel 6..1
  input wire [11:0] stage_code_in, // Live 2-bit codes, channel 6..1, 11 = ok
  input wire [5:0] stage_overheat_in, // Live over-temperature, high = hot
  output wire [5:0] switch_on, // Power stage on, channel 6..1
  output wire fault_flag_n // General fault flag, low on any stored channel fault code
);
  // Frame states
  localparam [1:0] ST_WAIT = 2'd0; // Waiting for an instruction
  localparam [1:0] ST_INSTR = 2'd1; // Addressed, rest of instruction
  localparam [1:0] ST_DATA = 2'd2; // Data byte phase

  wire [`SYNC_W-1:0] raw; // Pin bundle before synchronising
  wire [`SYNC_W-1:0] sy; // Pin bundle after synchronising

  reg cs_prev_reg; // Select level one cycle ago
  reg sclk_prev_reg; // Serial clock level one cycle ago
  reg [1:0] state_reg; // Frame state
  reg [4:0] edge_cnt_reg; // Falling edges this frame, saturating
  reg [15:0] rx_reg; // Receive shift register
  reg [15:0] tx_reg; // Transmit shift register
  reg [7:0] instr_reg; // Latched instruction byte
  reg so_reg; // Serial out level
  reg so_oe_n_reg; // Serial out enable, low drives
  reg [7:0] source_reg; // control_source_select
  reg [7:0] switch_reg; // serial_switch_state
  reg [11:0] code_reg; // Stored channel_error_code, channel 6..1
  reg ot_reg; // common_overheat_bit, low after heat seen
  reg [5:0] switch_on_reg; // Power stage drive
  reg fault_flag_n_reg; // General fault flag

  wire cs_s; // Synchronised select
  wire sclk_s; // Synchronised serial clock
  wire si_s; // Synchronised serial input
  wire hold_clear; // Reset pin or under-voltage active
  wire cs_fall; // Select just went low
  wire cs_rise; // Select just went high
  wire sclk_fall; // Falling serial clock edge while selected
  wire sclk_rise; // Rising serial clock edge while selected
  wire [4:0] edge_cnt_inc; // Saturating next edge count
  wire [7:0] instr_now; // Instruction as of the eighth falling edge
  wire frame_ok; // Addressed frame with exactly 16 edges ends now
  wire [5:0] opcode; // Upper six bits of the latched instruction
  wire clear_faults; // Qualifying read-fault frame ends now
  wire common_error; // High when no channel holds a fault
  wire any_hot; // Some stage reports over-temperature
  reg [7:0] second_byte; // Second output byte for the current instruction

  // All pins come from outside this clock domain
  assign raw = {stage_overheat_in, stage_code_in, parallel_control_input,
                input_polarity_pin, undervoltage, reset_n, si, sclk, cs_n};

  pin_sync #(
    .WIDTH(`SYNC_W),
    .INIT(`SYNC_INIT)
  ) u_pin_sync (
    .clk(clk),
    .rst(rst),
    .d(raw),
    .q(sy)
  );

  assign cs_s = sy[`SY_CS];
  assign sclk_s = sy[`SY_SCLK];
  assign si_s = sy[`SY_SI];
  assign hold_clear = ~sy[`SY_RESET_N] | sy[`SY_UV];

  // edges found by oversampling
  // Serial clock is sampled, never used as a clock, so 5 MBaud needs
  // the high and low times to span at least two system clocks.
  assign cs_fall = cs_prev_reg & ~cs_s;
  assign cs_rise = ~cs_prev_reg & cs_s;
  assign sclk_fall = ~cs_s & sclk_prev_reg & ~sclk_s;
  assign sclk_rise = ~cs_s & ~sclk_prev_reg & sclk_s;

  assign edge_cnt_inc = (edge_cnt_reg == `EDGE_CNT_MAX) ? edge_cnt_reg
                        : edge_cnt_reg + `EDGE_CNT_ONE;
  // first received bit ends up highest
  assign instr_now = {rx_reg[6:0], si_s};

  assign frame_ok = cs_rise & (state_reg == ST_DATA) &
                    (edge_cnt_reg == `FRAME_EDGES);
  assign opcode = instr_reg[7:2];
  assign clear_faults = frame_ok & (opcode == `OP_READ_FAULT);

  assign common_error = &code_reg;
  assign any_hot = |sy[`SY_HOT_HI:`SY_HOT_LO];

  // Second output byte, chosen once the instruction is complete
  always @* begin
    case (instr_now[7:2])
      `OP_READ_SWITCH: begin
        second_byte = switch_reg;
      end
      `OP_READ_SOURCE: begin
        second_byte = source_reg;
      end
      // channel 4..1 codes kept from the snapshot
      default: begin
        second_byte = tx_reg[15:8];
      end
    endcase
  end

  // Edge history for select and serial clock
  always @(posedge clk) begin
    if (rst) begin
      cs_prev_reg <= 1'b1;
      sclk_prev_reg <= 1'b0;
    end else begin
      cs_prev_reg <= cs_s;
      sclk_prev_reg <= sclk_s;
    end
  end

  // Frame engine: state, edge count, shifters, serial output
  always @(posedge clk) begin
    if (rst || hold_clear) begin
      state_reg <= ST_WAIT;
      edge_cnt_reg <= 5'd0;
      rx_reg <= 16'h0000;
      tx_reg <= 16'h0000;
      instr_reg <= 8'h00;
      so_reg <= 1'b0;
      so_oe_n_reg <= 1'b1;
    end else if (cs_s) begin
      state_reg <= ST_WAIT;
      edge_cnt_reg <= 5'd0;
      so_oe_n_reg <= 1'b1;
    end else if (cs_fall) begin
      tx_reg <= {`Z_FILL, common_error, ot_reg, code_reg};
      rx_reg <= 16'h0000;
      edge_cnt_reg <= 5'd0;
      state_reg <= ST_WAIT;
    end else begin
      if (sclk_fall) begin
        rx_reg <= {rx_reg[14:0], si_s};
        edge_cnt_reg <= edge_cnt_inc;
        case (state_reg)
          ST_WAIT: begin
            if (edge_cnt_reg == `ADDR_LAST_EDGE) begin
              if (instr_now[1:0] == `ADDR_MATCH) begin
                state_reg <= ST_INSTR;
              end else begin
                state_reg <= ST_WAIT;
              end
            end
          end
          ST_INSTR: begin
            if (edge_cnt_reg == `INSTR_LAST_EDGE) begin
              instr_reg <= instr_now;
              tx_reg[15:8] <= second_byte;
              state_reg <= ST_DATA;
            end
          end
          default: begin
            // Data byte: state holds; only the count and the receive shifter move on
            state_reg <= state_reg;
          end
        endcase
      end
      if (sclk_rise) begin
        // shift out on rising edge, MSB first
        so_reg <= tx_reg[15];
        tx_reg <= {tx_reg[14:0], 1'b0};
        so_oe_n_reg <= (state_reg == ST_WAIT);
      end
    end
  end

  // Control registers, written only at the end of a valid frame
  always @(posedge clk) begin
    if (rst || hold_clear) begin
      source_reg <= `REG_RESET;
      switch_reg <= `REG_RESET;
    end else if (frame_ok) begin
      // reads and unused codes write nothing
      if (opcode == `OP_WRITE_SWITCH) begin
        switch_reg <= {rx_reg[7:2], `FILL_BITS};
      end else if (opcode == `OP_WRITE_SOURCE) begin
        source_reg <= {rx_reg[7:2], `FILL_BITS};
      end
    end
  end

  // Common over-temperature bit; a new event beats a clear
  always @(posedge clk) begin
    if (rst || hold_clear) begin
      ot_reg <= `OT_NONE;
    end else if (any_hot) begin
      ot_reg <= `OT_SEEN;
    end else if (clear_faults) begin
      ot_reg <= `OT_NONE;
    end
  end

  // Per-channel fault storage and output drive
  genvar ch;
  generate
    for (ch = 0; ch < 6; ch = ch + 1) begin : g_chan
      wire [1:0] live_code; // Live code of this stage
      wire src_parallel; // Source bit of this channel
      wire par_level; // Parallel input of this channel
      assign live_code = sy[`SY_CODE_LO + 2*ch + 1:`SY_CODE_LO + 2*ch];
      assign src_parallel = source_reg[ch + 2];
      assign par_level = sy[`SY_PAR_LO + ch];

      // Last detected fault is kept; a new fault beats a clear
      always @(posedge clk) begin
        if (rst || hold_clear) begin
          code_reg[2*ch + 1:2*ch] <= `CODE_OK;
        end else if (live_code != `CODE_OK) begin
          code_reg[2*ch + 1:2*ch] <= live_code;
        end else if (clear_faults) begin
          code_reg[2*ch + 1:2*ch] <= `CODE_OK;
        end
      end

      // Output stage drive
      always @(posedge clk) begin
        if (rst || hold_clear) begin
          switch_on_reg[ch] <= 1'b0;
        end else if (src_parallel) begin
          switch_on_reg[ch] <= (par_level == sy[`SY_POL]);
        end else begin
          switch_on_reg[ch] <= ~switch_reg[ch + 2];
        end
      end
    end
  endgenerate

  // General fault flag follows the stored codes
  always @(posedge clk) begin
    if (rst || hold_clear) begin
      fault_flag_n_reg <= 1'b1;
    end else begin
      fault_flag_n_reg <= common_error;
    end
  end

  assign so_out = so_reg;
  assign so_oe_n = so_oe_n_reg;
  assign switch_on = switch_on_reg;
  assign fault_flag_n = fault_flag_n_reg;
endmodule // six_channel_switch_spi_slave

// file: tb/spi_master_model.sv
// Serial master model that frames commands for the switch interface
`timescale 1ns/1ps
module spi_master_model (
  input wire clk, // Bench clock
  output reg cs_n, // Select, idle high
  output reg sclk, // Serial clock, idle low; pulsed between frames only by idle_pulses
  output reg si, // Command bits
  input wire so_out, // Reply level
  input wire so_oe_n // Reply enable, low while driven
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    si = 1'b0;
  end
  // Half of a 125 ns link clock period
  localparam real half_ns = 62.5;
  // A 2.25 ns offset keeps every pin change off a system clock edge
  localparam real skew_ns = 2.25;

  // clock low at select edges
  // The link runs on its own time base, as a real master would
  task xfer(input [15:0] tx, input [4:0] n, output [15:0] rx);
    integer i;
    begin
      rx = 16'hffff;
      @(posedge clk);
      #(skew_ns);
      cs_n = 1'b0;
      // Lead time before the first rising edge
      #(half_ns);
      for (i = 0; i < n; i = i + 1) begin
        si = tx[15 - (i & 15)];
        sclk = 1'b1;
        #(half_ns);
        // A floating reply reads as high
        if (i < 16) rx[15 - i] = so_oe_n ? 1'b1 : so_out;
        sclk = 1'b0;
        #(half_ns);
      end
      cs_n = 1'b1;
      // Released data line no longer shows the last bit
      si = ~si;
      #(half_ns);
      @(posedge clk);
    end
  endtask

  // clock pulses with select high, which the slave must ignore
  task idle_pulses(input [4:0] n);
    integer j;
    begin
      @(posedge clk);
      #(skew_ns);
      for (j = 0; j < n; j = j + 1) begin
        si = ~si;
        sclk = 1'b1;
        #(half_ns);
        sclk = 1'b0;
        #(half_ns);
      end
      @(posedge clk);
    end
  endtask
endmodule // spi_master_model

// file: tb/six_channel_switch_spi_props.sv
// Concurrent checks on the switch interface pins
`timescale 1ns/1ps
module six_channel_switch_spi_props (
  input wire clk, // System clock
  input wire rst, // Synchronous reset
  input wire cs_n, // Select pin
  input wire sclk, // Serial clock pin
  input wire so_out, // Reply level
  input wire so_oe_n, // Reply enable, low while driven
  input wire reset_n, // External reset pin
  input wire undervoltage, // Supply low detector
  input wire [11:0] stage_code_in, // Live stage codes
  input wire [5:0] switch_on, // Stage drive
  input wire fault_flag_n // Stored fault flag
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  reg sclk_seen_reg; // Serial clock pin at the previous sample
  reg [1:0] rise_cnt_reg; // Serial clock rises this frame, stops at three

  // Count the first three clock rises of each frame
  // The reply may only be enabled after the third rise, so the check follows
  // the link itself and not the master's lead time.
  always @(posedge clk) begin
    if (rst || cs_n) begin
      rise_cnt_reg <= 2'd0;
    end else if (sclk && !sclk_seen_reg && rise_cnt_reg != 2'd3) begin
      rise_cnt_reg <= rise_cnt_reg + 2'd1;
    end
    sclk_seen_reg <= sclk;
  end

  reset_off_a: assert property (!reset_n [*4] |-> so_oe_n && switch_on == 6'h00)
    else $error("reset pin left outputs active");
  uv_off_a: assert property (undervoltage [*4] |-> switch_on == 6'h00)
    else $error("undervoltage left outputs on");
  idle_float_a: assert property (cs_n [*6] |-> so_oe_n)
    else $error("reply driven while deselected");
  drive_sel_a: assert property ($fell(so_oe_n) |-> !cs_n)
    else $error("reply enabled outside a frame");
  addr_float_a: assert property ($fell(cs_n) |-> so_oe_n [*8])
    else $error("reply driven during address bits");
  addr_gate_a: assert property (!cs_n && rise_cnt_reg != 2'd3 |-> so_oe_n)
    else $error("reply driven before the address check");
  out_steady_a: assert property ((!sclk [*4]) ##0 !so_oe_n |-> $stable(so_out))
    else $error("reply moved without a clock rise");
  flag_set_a: assert property ((stage_code_in != 12'hfff && reset_n
    && !undervoltage) [*4] |-> ##[0:4] !fault_flag_n)
    else $error("stage fault not stored");
  // A reset pin seen at one sample clears the flag three samples later
  flag_clear_a: assert property ($rose(fault_flag_n) |-> $past(cs_n, 2)
    || !$past(reset_n, 3) || !$past(reset_n, 4) || $past(undervoltage, 3)
    || $past(undervoltage, 4))
    else $error("fault cleared inside a frame");
endmodule // six_channel_switch_spi_props
bind six_channel_switch_spi_slave six_channel_switch_spi_props i_props (.clk(clk), .rst(rst),
  .cs_n(cs_n), .sclk(sclk), .so_out(so_out), .so_oe_n(so_oe_n), .reset_n(reset_n),
  .undervoltage(undervoltage), .stage_code_in(stage_code_in), .switch_on(switch_on),
  .fault_flag_n(fault_flag_n));

// file: tb/tb_six_channel_switch_spi_slave.sv
// Directed bench for the six-channel switch serial interface
`timescale 1ns/1ps
module tb_six_channel_switch_spi_slave;
  reg clk, rst, reset_n, undervoltage, input_polarity_pin; // Bench-driven pins
  reg [5:0] parallel_control_input; // Parallel inputs
  reg [11:0] stage_code_in; // Live stage codes
  reg [5:0] stage_overheat_in; // Live heat flags
  wire cs_n, sclk, si, so_out, so_oe_n, fault_flag_n; // Link and flag
  wire [5:0] switch_on; // Stage drive
  integer failures, n_checks, k; // Score and loop
  six_channel_switch_spi_slave i_six_channel_switch_spi_slave (.clk(clk), .rst(rst),
    .cs_n(cs_n), .sclk(sclk), .si(si), .so_out(so_out), .so_oe_n(so_oe_n),
    .reset_n(reset_n), .undervoltage(undervoltage), .input_polarity_pin(input_polarity_pin),
    .parallel_control_input(parallel_control_input), .stage_code_in(stage_code_in),
    .stage_overheat_in(stage_overheat_in), .switch_on(switch_on), .fault_flag_n(fault_flag_n));
  spi_master_model i_master (.clk(clk), .cs_n(cs_n), .sclk(sclk), .si(si), .so_out(so_out),
    .so_oe_n(so_oe_n));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Compare and count
  task chk(input [15:0] s, input [15:0] e);
    begin
      n_checks = n_checks + 1;
      if (s !== e) begin
        failures = failures + 1;
        $display("MISMATCH %0t seen %h expected %h", $time, s, e);
      end
    end
  endtask
  // One frame, reply compared
  task fr(input [15:0] tx, input [4:0] n, input [15:0] e);
    reg [15:0] rx;
    begin
      i_master.xfer(tx, n, rx);
      chk(rx, e);
    end
  endtask
  task final_report;
    begin
      if (failures == 0 && n_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask
  // Hang guard, far beyond the planned frame count
  initial begin
    repeat (30000) @(posedge clk);
    failures = failures + 1;
    final_report;
  end
  initial begin
    failures = 0;
    n_checks = 0;
    rst = 1'b1;
    reset_n = 1'b1;
    undervoltage = 1'b0;
    input_polarity_pin = 1'b1;
    parallel_control_input = 6'h33;
    stage_code_in = 12'hfff;
    stage_overheat_in = 6'h00;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    fr(16'h9400, 16, 16'hffff);
    fr(16'ha400, 16, 16'hffff);
    chk(switch_on, 16'h0033);
    fr(16'ha800, 16, 16'hffff);
    fr(16'h9854, 16, 16'hffff);
    chk(switch_on, 16'h002a);
    fr(16'h94ff, 16, 16'hff57);
    fr(16'ha4ff, 16, 16'hff03);
    // Refused frames and an unused instruction code must leave the switch register alone
    fr(16'h98fc, 15, 16'hffff);
    fr(16'h98fc, 17, 16'hffff);
    fr(16'hd8fc, 16, 16'hffff);
    fr(16'hb0fc, 16, 16'hffff);
    fr(16'h9400, 16, 16'hff57);
    // Clock pulses while deselected must not spoil the next frame's count
    i_master.idle_pulses(5'd3);
    fr(16'h9800, 16, 16'hffff);
    fr(16'h9400, 16, 16'hff03);
    chk(switch_on, 16'h003f);
    stage_code_in <= 12'h3fd;
    stage_overheat_in <= 6'h01;
    repeat (8) @(posedge clk);
    stage_code_in <= 12'hfff;
    stage_overheat_in <= 6'h00;
    repeat (8) @(posedge clk);
    chk(fault_flag_n, 16'h0000);
    fr(16'h9854, 16, 16'hc3fd);
    fr(16'h8000, 15, 16'hc3fd);
    fr(16'h8000, 16, 16'hc3fd);
    fr(16'h8000, 16, 16'hffff);
    chk(fault_flag_n, 16'h0001);
    fr(16'ha8fc, 16, 16'hffff);
    input_polarity_pin <= 1'b0;
    repeat (8) @(posedge clk);
    chk(switch_on, 16'h000c);
    // Pin reset then undervoltage, each must restore register defaults
    for (k = 0; k < 2; k = k + 1) begin
      fr(16'ha800, 16, 16'hffff);
      // Store a channel 6 fault so that the reset has something to clear
      stage_code_in <= 12'h3ff;
      repeat (8) @(posedge clk);
      stage_code_in <= 12'hfff;
      if (k == 0) reset_n <= 1'b0;
      else undervoltage <= 1'b1;
      repeat (8) @(posedge clk);
      chk(switch_on, 16'h0000);
      chk(fault_flag_n, 16'h0001);
      reset_n <= 1'b1;
      undervoltage <= 1'b0;
      repeat (8) @(posedge clk);
      fr(16'ha400, 16, 16'hffff);
    end
    final_report;
  end
endmodule // tb_six_channel_switch_spi_slave
